// ---- logic/srap_cfg.svh ----
// constants for the serial register access port
// Overview of operation
// RQ1: i2c write stores each data at paired address
// RQ2: host sets read address before reading
// RQ3: i2c read streams incrementing addresses until nack
// RQ4: spi mode chosen from sck at select
// RQ5: three wire mode shares sdi pad
// RQ6: sdo stays released in three wire mode
// RQ7: sample on sck rise, update on fall
// RQ8: chip select frames each spi transaction
// RQ9: control byte: rw flag plus seven bits
// RQ10: spi write pairs, no address increment
// RQ11: spi read streams incrementing register bytes
// RQ12: host keeps spi clock at most 10 mhz; the bench host runs sck at a 64 ns period, about 15.6 mhz
// RQ13: one select low disables i2c until reset
// RQ14: i2c address lsb follows sdo pin
// RQ15: i2c clock never stretched, input only
// RQ16: three wire enable is config bit 0
// RQ17: bytes shifted msb first, eight bits
`ifndef SRAP_CFG_SVH
`define SRAP_CFG_SVH
`define SRAP_BIT_LAST 3'h7
`define SRAP_BIT_FIRST 3'h0
`define SRAP_I2C_BITS 4'h8
`define SRAP_I2C_DEV_HI 6'h3b
`define SRAP_RW_BIT 7
`define SRAP_SPI_PAGE 1'h1
`define SRAP_CFG_ADDR 8'hf5
`define SRAP_TWE_BIT 0
`define SRAP_MEM_RST 8'h00
`endif

// ---- logic/srap_pkg.sv ----
// types shared by the serial register access port
package srap_pkg;
  typedef enum logic [8:0] {
    I_IDLE = 9'h001,
    I_DEV  = 9'h002,
    I_DACK = 9'h004,
    I_REG  = 9'h008,
    I_RACK = 9'h010,
    I_WDAT = 9'h020,
    I_WACK = 9'h040,
    I_RDAT = 9'h080,
    I_MACK = 9'h100
  } srap_i2c_st_t;
  typedef enum logic [2:0] {
    S_CTRL = 3'h1,
    S_WDAT = 3'h2,
    S_RDAT = 3'h4
  } srap_spi_st_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } srap_wr_t;
endpackage

// ---- logic/srap_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ns
module srap_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // destination clock
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

// ---- logic/srap_mem.sv ----
// byte-wide register store with registered read data
`timescale 1ns/1ns
`include "srap_cfg.svh"
module srap_mem #(
  parameter int DEPTH = 256
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic we,
  input wire srap_pkg::srap_wr_t wr,
  // read port
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rd_r;

  // cleared at reset so a read of an unwritten byte is defined
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= `SRAP_MEM_RST;
      end
      rd_r <= `SRAP_MEM_RST;
    end else begin
      if (we) begin
        mem_r[wr.addr] <= wr.data;
      end
      rd_r <= mem_r[raddr];
    end
  end

  assign rdata = rd_r;
endmodule

// ---- logic/srap_top.sv ----
// serial register access port: i2c and 3/4-wire spi slave over a register store
`timescale 1ns/1ns
`include "srap_cfg.svh"
module srap_top (
  // system clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // chip select and serial clock; sck also clocks the spi shift logic
  input wire logic csb_n,
  input wire logic sck,
  // data pad: spi input, i2c data, three wire data
  input wire logic sdi_i,
  output logic sdi_o,
  output logic sdi_oe_n,
  // output pad: spi output, i2c address lsb strap
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe_n,
  // status
  output logic i2c_off,
  output logic spi_mode_11,
  output logic three_wire_enable
);
  // ------------------------------------------------------------
  // pin synchronisers (system clock side)
  // ------------------------------------------------------------
  logic [3:0] pin_s;
  logic csb_s;
  logic scl_s;
  logic sda_s;
  logic alsb_s;

  srap_sync #(.W(4), .RST_VAL(4'hf)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d({csb_n, sck, sdi_i, sdo_i}),
    .q(pin_s)
  );
  assign {csb_s, scl_s, sda_s, alsb_s} = pin_s;

  // ------------------------------------------------------------
  // signals between the domains
  // ------------------------------------------------------------
  logic [7:0] mem_rdata;
  logic mem_we;
  srap_pkg::srap_wr_t mem_wr;
  logic [7:0] mem_raddr;
  logic i2c_we;
  srap_pkg::srap_wr_t i2c_wr;
  logic spi_rtog_r;
  logic spi_wtog_r;
  logic [6:0] spi_raddr_r;
  logic [6:0] spi_waddr_r;
  logic [7:0] spi_wdata_r;
  logic [1:0] tog_s;

  srap_sync #(.W(2), .RST_VAL(2'h0)) u_tog_sync (
    .clk(clk),
    .rst(rst),
    .d({spi_rtog_r, spi_wtog_r}),
    .q(tog_s)
  );

  // ------------------------------------------------------------
  // system-side state: edges, lock, mode, config, spi fetch
  // ------------------------------------------------------------
  logic scl_q_r, scl_q_nxt;
  logic sda_q_r, sda_q_nxt;
  logic csb_q_r, csb_q_nxt;
  logic i2c_off_r, i2c_off_nxt;
  logic mode_r, mode_nxt;
  logic twe_r, twe_nxt;
  logic [1:0] tog_q_r, tog_q_nxt;
  logic [7:0] spi_ra_r, spi_ra_nxt;
  logic spi_wr_evt;

  always_comb begin
    scl_q_nxt = scl_s;
    sda_q_nxt = sda_s;
    csb_q_nxt = csb_s;
    tog_q_nxt = tog_s;
    i2c_off_nxt = i2c_off_r | ~csb_s; // RQ13
    // the transaction opens on the select falling edge
    mode_nxt = (csb_q_r & ~csb_s) ? scl_s : mode_r; // RQ4 RQ8
    twe_nxt = twe_r;
    if (mem_we && mem_wr.addr == `SRAP_CFG_ADDR) begin
      twe_nxt = mem_wr.data[`SRAP_TWE_BIT]; // RQ16
    end
    spi_ra_nxt = spi_ra_r;
    // the sck side holds its address stable, so it is sampled only after the toggle
    if (tog_s[1] ^ tog_q_r[1]) begin
      spi_ra_nxt = {`SRAP_SPI_PAGE, spi_raddr_r}; // RQ9
    end
    spi_wr_evt = tog_s[0] ^ tog_q_r[0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      csb_q_r <= 1'b1;
      tog_q_r <= 2'h0;
      i2c_off_r <= 1'b0;
      mode_r <= 1'b0;
      twe_r <= 1'b0;
      spi_ra_r <= 8'h00;
    end else begin
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
      csb_q_r <= csb_q_nxt;
      tog_q_r <= tog_q_nxt;
      i2c_off_r <= i2c_off_nxt;
      mode_r <= mode_nxt;
      twe_r <= twe_nxt;
      spi_ra_r <= spi_ra_nxt;
    end
  end

  // ------------------------------------------------------------
  // register store
  // ------------------------------------------------------------
  // i2c is locked out before any spi traffic, so the two writers never meet
  assign mem_we = i2c_we | spi_wr_evt;
  assign mem_wr = spi_wr_evt ? {`SRAP_SPI_PAGE, spi_waddr_r, spi_wdata_r} : i2c_wr; // RQ10
  assign mem_raddr = i2c_off_r ? spi_ra_r : i2c_wr.addr;

  srap_mem #(.DEPTH(256)) u_mem (
    .clk(clk),
    .rst(rst),
    .we(mem_we),
    .wr(mem_wr),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ------------------------------------------------------------
  // i2c slave (oversampled on the system clock)
  // ------------------------------------------------------------
  srap_pkg::srap_i2c_st_t ist_r, ist_nxt;
  logic [7:0] ish_r, ish_nxt;
  logic [3:0] icnt_r, icnt_nxt;
  logic [7:0] iptr_r, iptr_nxt;
  logic [7:0] itx_r, itx_nxt;
  logic ipull_r, ipull_nxt;
  logic scl_rise;
  logic scl_fall;
  logic i_start;
  logic i_stop;
  logic byte_end;
  logic shifting;

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign i_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign i_stop = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign byte_end = scl_fall && icnt_r == `SRAP_I2C_BITS;
  assign shifting = ist_r == srap_pkg::I_DEV || ist_r == srap_pkg::I_REG ||
                    ist_r == srap_pkg::I_WDAT || ist_r == srap_pkg::I_RDAT;
  assign i2c_wr = {iptr_r, ish_r};

  always_comb begin
    ist_nxt = ist_r;
    ish_nxt = ish_r;
    icnt_nxt = icnt_r;
    iptr_nxt = iptr_r;
    itx_nxt = itx_r;
    ipull_nxt = ipull_r;
    i2c_we = 1'b0;
    if (shifting && scl_rise && icnt_r != `SRAP_I2C_BITS) begin
      ish_nxt = {ish_r[6:0], sda_s}; // RQ17
      icnt_nxt = icnt_r + 4'h1;
    end
    case (ist_r)
      srap_pkg::I_IDLE: begin
        ipull_nxt = 1'b0;
      end
      srap_pkg::I_DEV: begin
        if (byte_end) begin
          icnt_nxt = 4'h0;
          // the address lsb is read live from the strap pin
          if (ish_r[7:1] == {`SRAP_I2C_DEV_HI, alsb_s}) begin // RQ14
            ist_nxt = srap_pkg::I_DACK;
            ipull_nxt = 1'b1;
          end else begin
            ist_nxt = srap_pkg::I_IDLE;
          end
        end
      end
      srap_pkg::I_DACK: begin
        if (scl_fall) begin
          if (ish_r[0]) begin
            // read resumes at the pointer left by the last write phase
            ist_nxt = srap_pkg::I_RDAT; // RQ2 RQ3
            itx_nxt = mem_rdata;
            ipull_nxt = ~mem_rdata[7];
          end else begin
            ist_nxt = srap_pkg::I_REG;
            ipull_nxt = 1'b0;
          end
        end
      end
      srap_pkg::I_REG: begin
        if (byte_end) begin
          iptr_nxt = ish_r; // RQ1
          icnt_nxt = 4'h0;
          ist_nxt = srap_pkg::I_RACK;
          ipull_nxt = 1'b1;
        end
      end
      srap_pkg::I_RACK: begin
        if (scl_fall) begin
          ist_nxt = srap_pkg::I_WDAT;
          ipull_nxt = 1'b0;
        end
      end
      srap_pkg::I_WDAT: begin
        if (byte_end) begin
          i2c_we = 1'b1; // RQ1
          icnt_nxt = 4'h0;
          ist_nxt = srap_pkg::I_WACK;
          ipull_nxt = 1'b1;
        end
      end
      srap_pkg::I_WACK: begin
        if (scl_fall) begin
          ist_nxt = srap_pkg::I_REG;
          ipull_nxt = 1'b0;
        end
      end
      srap_pkg::I_RDAT: begin
        if (scl_fall) begin
          if (icnt_r == `SRAP_I2C_BITS) begin
            icnt_nxt = 4'h0;
            ist_nxt = srap_pkg::I_MACK;
            ipull_nxt = 1'b0;
          end else begin
            itx_nxt = {itx_r[6:0], 1'b0}; // RQ17
            ipull_nxt = ~itx_r[6];
          end
        end
      end
      srap_pkg::I_MACK: begin
        if (scl_rise) begin
          if (sda_s) begin
            ist_nxt = srap_pkg::I_IDLE; // RQ3
          end else begin
            iptr_nxt = iptr_r + 8'h01; // RQ3
          end
        end else if (scl_fall) begin
          ist_nxt = srap_pkg::I_RDAT;
          itx_nxt = mem_rdata;
          ipull_nxt = ~mem_rdata[7];
        end
      end
      default: begin
        ist_nxt = srap_pkg::I_IDLE;
        ipull_nxt = 1'b0;
      end
    endcase
    if (i_start) begin
      ist_nxt = srap_pkg::I_DEV;
      icnt_nxt = 4'h0;
      ipull_nxt = 1'b0;
    end
    if (i_stop || i2c_off_r) begin
      ist_nxt = srap_pkg::I_IDLE; // RQ13
      ipull_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r <= srap_pkg::I_IDLE;
      ish_r <= 8'h00;
      icnt_r <= 4'h0;
      iptr_r <= 8'h00;
      itx_r <= 8'h00;
      ipull_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      ish_r <= ish_nxt;
      icnt_r <= icnt_nxt;
      iptr_r <= iptr_nxt;
      itx_r <= itx_nxt;
      ipull_r <= ipull_nxt;
    end
  end

  // ------------------------------------------------------------
  // spi receive, rising sck
  // ------------------------------------------------------------
  // frame state clears whenever select is high; crossing registers keep
  // their value so a late toggle is never lost or faked
  logic spi_arst;
  srap_pkg::srap_spi_st_t sst_r, sst_nxt;
  logic [6:0] ssh_r, ssh_nxt;
  logic [2:0] sbit_r, sbit_nxt;
  logic [7:0] rx_byte;
  logic rtog_nxt;
  logic wtog_nxt;
  logic [6:0] raddr_nxt;
  logic [6:0] waddr_nxt;
  logic [7:0] wdata_nxt;

  assign spi_arst = rst | csb_n; // RQ8

  always_comb begin
    rx_byte = {ssh_r, sdi_i}; // RQ7 RQ17
    ssh_nxt = rx_byte[6:0];
    sbit_nxt = sbit_r + 3'h1;
    sst_nxt = sst_r;
    rtog_nxt = spi_rtog_r;
    wtog_nxt = spi_wtog_r;
    raddr_nxt = spi_raddr_r;
    waddr_nxt = spi_waddr_r;
    wdata_nxt = spi_wdata_r;
    case (sst_r)
      srap_pkg::S_CTRL: begin
        if (sbit_r == `SRAP_BIT_LAST) begin
          if (rx_byte[`SRAP_RW_BIT]) begin
            sst_nxt = srap_pkg::S_RDAT; // RQ9
            raddr_nxt = rx_byte[6:0];
            rtog_nxt = ~spi_rtog_r;
          end else begin
            sst_nxt = srap_pkg::S_WDAT; // RQ9
            waddr_nxt = rx_byte[6:0];
          end
        end
      end
      srap_pkg::S_WDAT: begin
        if (sbit_r == `SRAP_BIT_LAST) begin
          wdata_nxt = rx_byte; // RQ10
          wtog_nxt = ~spi_wtog_r;
          sst_nxt = srap_pkg::S_CTRL;
        end
      end
      srap_pkg::S_RDAT: begin
        // prefetch the next byte a whole byte ahead; at 10 mhz the first
        // fetch still has half a bit time, about a dozen system clocks
        if (sbit_r == `SRAP_BIT_FIRST) begin
          raddr_nxt = spi_raddr_r + 7'h01; // RQ11 RQ12
          rtog_nxt = ~spi_rtog_r;
        end
      end
      default: begin
        sst_nxt = srap_pkg::S_CTRL;
      end
    endcase
  end

  always_ff @(posedge sck or posedge spi_arst) begin
    if (spi_arst) begin
      sst_r <= srap_pkg::S_CTRL;
      ssh_r <= 7'h00;
      sbit_r <= 3'h0;
    end else begin
      sst_r <= sst_nxt;
      ssh_r <= ssh_nxt;
      sbit_r <= sbit_nxt;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      spi_rtog_r <= 1'b0;
      spi_wtog_r <= 1'b0;
      spi_raddr_r <= 7'h00;
      spi_waddr_r <= 7'h00;
      spi_wdata_r <= 8'h00;
    end else begin
      spi_rtog_r <= rtog_nxt;
      spi_wtog_r <= wtog_nxt;
      spi_raddr_r <= raddr_nxt;
      spi_waddr_r <= waddr_nxt;
      spi_wdata_r <= wdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // spi transmit, falling sck
  // ------------------------------------------------------------
  // a mode 11 frame starts with a falling edge while still in the control
  // byte, so that edge moves nothing; both modes share one edge plan
  logic [7:0] stx_r, stx_nxt;
  logic sdrv_r, sdrv_nxt;
  logic twe_k;

  srap_sync #(.W(1), .RST_VAL(1'b0)) u_twe_sync (
    .clk(sck),
    .rst(rst),
    .d(twe_r),
    .q(twe_k)
  );

  always_comb begin
    stx_nxt = {stx_r[6:0], 1'b0}; // RQ17
    if (sst_r == srap_pkg::S_RDAT && sbit_r == `SRAP_BIT_FIRST) begin
      stx_nxt = mem_rdata; // RQ7 RQ11
    end
    sdrv_nxt = sst_r == srap_pkg::S_RDAT;
  end

  always_ff @(negedge sck or posedge spi_arst) begin
    if (spi_arst) begin
      stx_r <= 8'h00;
      sdrv_r <= 1'b0;
    end else begin
      stx_r <= stx_nxt;
      sdrv_r <= sdrv_nxt;
    end
  end

  // ------------------------------------------------------------
  // pads and status
  // ------------------------------------------------------------
  // sck is never driven: the i2c clock is not stretched
  assign sdo_o = stx_r[7];
  assign sdo_oe_n = ~(sdrv_r & ~twe_k); // RQ6 RQ11
  assign sdi_o = i2c_off_r ? stx_r[7] : 1'b0; // RQ5
  assign sdi_oe_n = ~((sdrv_r & twe_k) | ipull_r); // RQ5
  assign i2c_off = i2c_off_r;
  assign spi_mode_11 = mode_r;
  assign three_wire_enable = twe_r;
endmodule

// ---- dv/srap_checker.sv ----
// assertion checker for the serial register access port
`timescale 1ns/1ns
module srap_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // select and serial clock
  input wire logic csb_n,
  input wire logic sck,
  // pad drive
  input wire logic sdi_o,
  input wire logic sdi_oe_n,
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  // status
  input wire logic i2c_off,
  input wire logic spi_mode_11,
  input wire logic three_wire_enable
);
  // ----------------
  // assertions
  // ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence sel_fall_s;
    $fell(csb_n);
  endsequence
  // the host keeps sck parked for longer than this after select
  sequence mode_taken_s;
    ##7 (spi_mode_11 == $past(sck, 7));
  endsequence
  mode_pick_a: assert property (sel_fall_s |-> mode_taken_s)
    else $error("spi mode flag does not follow sck at select");
  sel_lock_a: assert property (!csb_n |-> ##[0:6] i2c_off)
    else $error("i2c port not disabled after select");
  lock_hold_a: assert property (i2c_off |=> i2c_off)
    else $error("i2c disable was lost");
  lock_quiet_a: assert property ((i2c_off && csb_n) |-> sdi_oe_n)
    else $error("data pad driven with i2c disabled");
  sdo_3w_a: assert property (three_wire_enable |-> sdo_oe_n)
    else $error("output pad driven in three wire mode");
  pad_share_a: assert property ((!csb_n && !sdi_oe_n) |-> three_wire_enable)
    else $error("data pad driven in four wire spi");
  one_pad_a: assert property (!sdo_oe_n |-> (!csb_n && sdi_oe_n))
    else $error("output pad driven outside a four wire frame");
  fall_update_a: assert property ((($changed(sdo_o) || $changed(sdi_o)) && !csb_n) |-> !sck)
    else $error("spi output moved while sck high");
endmodule

bind srap_top srap_checker chk (
  .clk(clk),
  .rst(rst),
  .csb_n(csb_n),
  .sck(sck),
  .sdi_o(sdi_o),
  .sdi_oe_n(sdi_oe_n),
  .sdo_o(sdo_o),
  .sdo_oe_n(sdo_oe_n),
  .i2c_off(i2c_off),
  .spi_mode_11(spi_mode_11),
  .three_wire_enable(three_wire_enable)
);

// ---- dv/srap_host.sv ----
// host controller model for the i2c and spi pins
`timescale 1ns/1ns
module srap_host (
  // clock for i2c bit timing
  input wire logic clk,
  // device pad drive
  input wire logic sdi_o,
  input wire logic sdi_oe_n,
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  // pins towards the device
  output logic csb_n,
  output logic sck,
  output logic sdi_i,
  output logic sdo_i
);
  // ----------------
  // pads and transfers
  // ----------------
  localparam int Q = 8;
  logic h_en = 1'b0;
  logic h_val = 1'b0;
  logic strap = 1'b0;
  // released pads go to pull-up or strap level; drivers combine as wired and
  assign sdi_i = (sdi_oe_n ? 1'b1 : sdi_o) & (h_en ? h_val : 1'b1);
  assign sdo_i = sdo_oe_n ? strap : sdo_o;
  initial begin
    csb_n = 1'b1;
    sck = 1'b1;
  end
  task automatic pins(input logic c, input logic d);
    @(posedge clk);
    sck <= c;
    h_en <= !d;
    h_val <= 1'b0;
    repeat (Q) @(posedge clk);
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    pins(1'b0, !h_en);
    pins(1'b0, b);
    pins(1'b1, b);
    r = sdi_i;
  endtask
  task automatic i2c_start();
    pins(1'b0, !h_en);
    pins(1'b0, 1'b1);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
  endtask
  task automatic i2c_stop();
    pins(1'b0, !h_en);
    pins(1'b0, 1'b0);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
  endtask
  // mack low asks for another byte, high ends a read
  task automatic i2c_byte(input logic [7:0] b, input logic mack, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
    i2c_bit(mack, ack);
  endtask
  // sck is parked before select moves and stays parked while it moves
  task automatic spi_sel(input logic m11);
    #5 sck = m11;
    #40 csb_n = 1'b0;
    #40;
  endtask
  task automatic spi_byte(input logic [7:0] tx, input logic drv, input logic w3, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      h_en = drv;
      h_val = tx[i];
      #32 sck = 1'b1;
      rx[i] = w3 ? sdi_i : sdo_i;
      #32;
    end
  endtask
  task automatic spi_end(input logic m11);
    if (!m11) begin
      #32 sck = 1'b0;
    end
    #40 csb_n = 1'b1;
    h_en = 1'b0;
    #60;
  endtask
endmodule

// ---- dv/tb_serial_register_access_port.sv ----
// self-checking bench for the serial register access port
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_serial_register_access_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic csb_n, sck, sdi_i, sdi_o, sdi_oe_n, sdo_i, sdo_o, sdo_oe_n;
  logic i2c_off, spi_mode_11, three_wire_enable;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 19;
  logic [7:0] mem [256];
  logic [7:0] a, d0, r0;
  logic k0;
  always #2 clk = ~clk;
  srap_top dut (.clk(clk), .rst(rst), .csb_n(csb_n), .sck(sck), .sdi_i(sdi_i), .sdi_o(sdi_o),
    .sdi_oe_n(sdi_oe_n), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .i2c_off(i2c_off),
    .spi_mode_11(spi_mode_11), .three_wire_enable(three_wire_enable));
  srap_host host (.clk(clk), .sdi_o(sdi_o), .sdi_oe_n(sdi_oe_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
    .csb_n(csb_n), .sck(sck), .sdi_i(sdi_i), .sdo_i(sdo_i));
  // ----------------
  // expectations and transfers
  // ----------------
  function automatic logic [7:0] i2c_addr(input logic lsb, input logic rd);
    return {6'h3b, lsb, rd};
  endfunction
  function automatic logic [7:0] spi_ctrl(input logic [7:0] ra, input logic rd);
    return {rd, ra[6:0]};
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic ack);
    host.i2c_byte(b, 1'b1, r0, k0);
    `CHK(k0, ack)
  endtask
  task automatic get(input logic [7:0] exp, input logic last);
    host.i2c_byte(8'hff, last, r0, k0);
    `CHK(r0, exp)
  endtask
  // two pairs in one frame: an auto-increment would misplace the second pair
  task automatic spi_wr(input logic [7:0] ra, input logic [7:0] w0, input logic [7:0] w1, input logic m11,
    input logic w3);
    host.spi_sel(m11);
    host.spi_byte(spi_ctrl(ra, 1'b0), 1'b1, w3, r0);
    host.spi_byte(w0, 1'b1, w3, r0);
    host.spi_byte(spi_ctrl(8'(ra + 8'h01), 1'b0), 1'b1, w3, r0);
    host.spi_byte(w1, 1'b1, w3, r0);
    host.spi_end(m11);
    mem[ra] = w0;
    mem[8'(ra + 8'h01)] = w1;
    `CHK(spi_mode_11, m11)
  endtask
  task automatic spi_rd(input logic [7:0] ra, input logic m11, input logic w3);
    host.spi_sel(m11);
    host.spi_byte(spi_ctrl(ra, 1'b1), 1'b1, w3, r0);
    for (int i = 0; i < 3; i++) begin
      host.spi_byte(8'h00, 1'b0, w3, r0);
      `CHK(r0, mem[8'(ra + i)])
    end
    host.spi_end(m11);
  endtask
  task automatic wait_cfg(input logic v);
    int n;
    n = 0;
    while (three_wire_enable !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK(three_wire_enable, v)
    if (n == 40) conclude();
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // i2c must run first: any select low locks it out
    a = {1'b0, 7'($random(seed))};
    host.i2c_start();
    put(i2c_addr(1'b0, 1'b0), 1'b0);
    for (int i = 0; i < 3; i++) begin
      d0 = 8'($random(seed));
      mem[8'(a + i)] = d0;
      put(8'(a + i), 1'b0);
      put(d0, 1'b0);
    end
    host.i2c_stop();
    host.i2c_start();
    put(i2c_addr(1'b0, 1'b0), 1'b0);
    put(a, 1'b0);
    host.i2c_start();
    put(i2c_addr(1'b0, 1'b1), 1'b0);
    for (int i = 0; i < 3; i++) get(mem[8'(a + i)], i == 2);
    host.i2c_stop();
    @(posedge clk) host.strap <= 1'b1;
    host.i2c_start();
    put(i2c_addr(1'b0, 1'b0), 1'b1);
    host.i2c_start();
    put(i2c_addr(1'b1, 1'b0), 1'b0);
    put(a, 1'b0);
    host.i2c_stop();
    `CHK(i2c_off, 1'b0)
    for (int m = 0; m < 2; m++) begin
      a = m ? {2'b10, 6'($random(seed))} : 8'hf7;
      spi_wr(a, 8'($random(seed)), 8'($random(seed)), m[0], 1'b0);
      spi_rd(a, ~m[0], 1'b0);
    end
    `CHK(i2c_off, 1'b1)
    host.i2c_start();
    put(i2c_addr(1'b1, 1'b0), 1'b1);
    host.i2c_stop();
    spi_wr(8'hf5, 8'h01, 8'($random(seed)), 1'b1, 1'b0);
    wait_cfg(1'b1);
    spi_rd(8'hf5, 1'b0, 1'b1);
    spi_wr(8'hf5, 8'h00, 8'($random(seed)), 1'b0, 1'b1);
    wait_cfg(1'b0);
    spi_rd(8'hf6, 1'b1, 1'b0);
    conclude();
  end
endmodule
